// >>> inc/clock_watchdog_regs.vh
// register map, field positions, reset values and timing for the watchdog
// Overview of operation
// - byte 8 bits 5:1 hold the five-bit timeout count, reset all ones
// - byte 8 bit 0 picks 150 ms or 2.5 sec per step, default 150 ms
// - short unit gives intervals from 150 ms up to 4.65 sec
// - long unit gives intervals from 2.5 sec up to 77.5 sec
// - countdown reaching zero sets the timeout flag
// - byte 9 bit 4 set lets expiry issue a system reset pulse
// - byte 9 bit 3 set lets a frequency change issue a reset pulse
// - byte 9 bit 2 reads timeout flag; writing one clears it
// - run bit at zero stops the countdown and reloads the count
// - run bit set starts the countdown after a frequency change
// - expiry issues reset if enabled, loads recovery rate, locks
// - while locked, writes that change output frequency are ignored
// - software clears the run bit to unlock frequency changes
// - byte 9 bits 7:5 hold usb, pci, mid-rate drive strength
// - byte 10 bit 4 fixes mid-rate at 64 MHz and pci at 32 MHz
// - byte 11 holds recovery divider n, used with m when source set
// - recovery ratio from latched pins, or software select on override
// - source select zero uses latched pins, one uses n and m fields
// - latched rate-select pins readable by software, read only
`ifndef CLOCK_WATCHDOG_REGS_VH
`define CLOCK_WATCHDOG_REGS_VH
`define REG_LATCHED_PINS 4'h5
`define REG_TIMEOUT_CFG 4'h8
`define REG_RESET_DRIVE 4'h9
`define REG_SKEW_FIXED 4'hA
`define REG_RECOVERY_N 4'hB
`define CFG_COUNT_HI 5
`define CFG_COUNT_LO 1
`define CFG_UNIT_BIT 0
`define CTL_USB_DRV_BIT 7
`define CTL_PCI_CLK_STRENGTH_BIT 6
`define CTL_MID_DRV_BIT 5
`define CTL_RST_EXP_BIT 4
`define CTL_RST_CHG_BIT 3
`define CTL_FLAG_BIT 2
`define CTL_RUN_BIT 1
`define SKW_FIXED_BIT 4
`define TIMEOUT_CFG_RESET 8'h3E
`define RESET_DRIVE_RESET 8'h00
`define SKEW_FIXED_RESET 8'h00
`define RECOVERY_N_RESET 8'h00
`define TIMEOUT_CFG_MASK 8'h3F
`define RESET_DRIVE_MASK 8'hFA
`define CLK_MHZ 25
`define UNIT_SHORT_US 150000
`define UNIT_LONG_US 2500000
`define SYS_RESET_CYCLES 16
`endif

// >>> core/clock_watchdog_recovery_ctrl.v
// watchdog countdown, recovery switch and control bytes of the clock synth
`include "clock_watchdog_regs.vh"
`default_nettype none
module clock_watchdog_recovery_ctrl #(
  parameter [31:0] SHORT_UNIT_CYCLES = `UNIT_SHORT_US * `CLK_MHZ,
  parameter [31:0] LONG_UNIT_CYCLES = `UNIT_LONG_US * `CLK_MHZ
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // control byte port from the smbus slave
  input wire [3:0] byte_index,
  input wire byte_write,
  input wire [7:0] byte_wdata,
  input wire byte_read,
  output reg [7:0] byte_rdata,
  // synthesizer side
  input wire freq_change,
  input wire [4:0] rate_select_pins,
  input wire rate_pin_override,
  input wire [4:0] sw_rate_sel,
  input wire fallback_source_sel,
  input wire [6:0] fallback_divider_m,
  // recovery and lock
  output reg recovery_load,
  output reg recovery_from_nm,
  output reg [7:0] recovery_n,
  output reg [6:0] recovery_m,
  output reg [4:0] recovery_rate_sel,
  output reg [4:0] recovery_ratio_sel,
  output reg freq_change_locked,
  // system reset
  output reg sys_reset,
  // output configuration
  output reg usb_clk_strength,
  output reg pci_clk_strength,
  output reg mid_clk_strength,
  output reg [2:0] cpu_clk_delay_trim,
  output reg locked_bus_rate_mode,
  output reg [1:0] pci_clk_delay_trim,
  output reg [1:0] mid_clk_delay_trim,
  output reg [4:0] latched_rate_pins,
  output wire timeout_flag_out
);

localparam ST_IDLE = 2'd0;
localparam ST_ARMED = 2'd1;
localparam ST_COUNT = 2'd2;
localparam ST_LOCKED = 2'd3;
localparam [31:0] RESET_LAST = `SYS_RESET_CYCLES - 1;

function [7:0] hit;
  input [3:0] idx;
  input [3:0] want;
  begin
    hit = (idx == want) ? 8'hFF : 8'h00;
  end
endfunction

function picked;
  input [3:0] idx;
  input [3:0] want;
  begin
    picked = (idx == want);
  end
endfunction

reg [7:0] timeout_cfg;
reg [4:0] timeout_count_hold;
reg timeout_unit_sel;
reg reset_on_expiry_en;
reg reset_on_rate_change_en;
reg timeout_flag;
reg watchdog_run;
reg [7:0] fallback_divider_n;
reg [1:0] state;
reg [4:0] countdown;
reg [31:0] unit_timer;
reg [4:0] reset_timer;
reg [4:0] pins_meta;
reg [4:0] pins_sync;
reg pins_latched;
reg [1:0] settle;
wire write_cfg;
wire write_ctl;
wire write_skew;
wire write_n;
wire unit_tick;
wire expire;
wire [31:0] unit_len;

assign write_cfg = byte_write & picked(byte_index, `REG_TIMEOUT_CFG);
assign write_ctl = byte_write & picked(byte_index, `REG_RESET_DRIVE);
assign write_skew = byte_write & picked(byte_index, `REG_SKEW_FIXED);
assign write_n = byte_write & picked(byte_index, `REG_RECOVERY_N);
assign timeout_flag_out = timeout_flag;

assign unit_len = timeout_unit_sel ? LONG_UNIT_CYCLES : SHORT_UNIT_CYCLES;
assign unit_tick = (state == ST_COUNT) && (unit_timer == unit_len - 32'd1);
// count of n gives n units, a count of zero gives one
assign expire = unit_tick && (countdown <= 5'd1);

always @* begin
  timeout_count_hold = timeout_cfg[`CFG_COUNT_HI:`CFG_COUNT_LO];
  timeout_unit_sel = timeout_cfg[`CFG_UNIT_BIT];
end

// pins cross from outside, two stages before use
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    pins_meta <= 5'h0_0;
    pins_sync <= 5'h0_0;
  end else begin
    pins_meta <= rate_select_pins;
    pins_sync <= pins_meta;
  end
end

// latch pins after reset
// wait two edges: the synchroniser is cleared by reset too
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    settle <= 2'h0;
    pins_latched <= 1'b0;
    latched_rate_pins <= 5'h0_0;
  end else if (settle != 2'h2) begin
    settle <= settle + 2'h1;
  end else if (!pins_latched) begin
    pins_latched <= 1'b1;
    latched_rate_pins <= pins_sync;
  end
end

// control bytes
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    timeout_cfg <= `TIMEOUT_CFG_RESET;
    usb_clk_strength <= 1'b0;
    pci_clk_strength <= 1'b0;
    mid_clk_strength <= 1'b0;
    reset_on_expiry_en <= 1'b0;
    reset_on_rate_change_en <= 1'b0;
    watchdog_run <= 1'b0;
    cpu_clk_delay_trim <= 3'h0;
    locked_bus_rate_mode <= 1'b0;
    pci_clk_delay_trim <= 2'h0;
    mid_clk_delay_trim <= 2'h0;
    fallback_divider_n <= `RECOVERY_N_RESET;
  end else begin
    // count and unit, top bits dropped
    if (write_cfg)
      timeout_cfg <= byte_wdata & `TIMEOUT_CFG_MASK;
    if (write_ctl) begin
      usb_clk_strength <= byte_wdata[`CTL_USB_DRV_BIT];
      pci_clk_strength <= byte_wdata[`CTL_PCI_CLK_STRENGTH_BIT];
      mid_clk_strength <= byte_wdata[`CTL_MID_DRV_BIT];
      reset_on_expiry_en <= byte_wdata[`CTL_RST_EXP_BIT];
      reset_on_rate_change_en <= byte_wdata[`CTL_RST_CHG_BIT];
      watchdog_run <= byte_wdata[`CTL_RUN_BIT];
    end
    if (write_skew) begin
      cpu_clk_delay_trim <= byte_wdata[7:5];
      // fixed rate changes frequency, held while locked
      if (state != ST_LOCKED)
        locked_bus_rate_mode <= byte_wdata[`SKW_FIXED_BIT];
      // pci trim, reserved code kept as written
      pci_clk_delay_trim <= byte_wdata[3:2];
      mid_clk_delay_trim <= byte_wdata[1:0];
    end
    if (write_n)
      fallback_divider_n <= byte_wdata;
  end
end

// flag: expiry wins over a clearing write
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    timeout_flag <= 1'b0;
  end else if (expire) begin
    timeout_flag <= 1'b1;
  end else if (write_ctl && byte_wdata[`CTL_FLAG_BIT]) begin
    timeout_flag <= 1'b0;
  end
end

// watchdog sequencer
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    state <= ST_IDLE;
    countdown <= 5'h1_F;
    unit_timer <= 32'h0000_0000;
  end else if (!watchdog_run) begin
    state <= ST_IDLE;
    countdown <= timeout_count_hold;
    unit_timer <= 32'h0000_0000;
  end else begin
    case (state)
      ST_IDLE: begin
        countdown <= timeout_count_hold;
        state <= ST_ARMED;
      end
      ST_ARMED: begin
        countdown <= timeout_count_hold;
        unit_timer <= 32'h0000_0000;
        if (freq_change)
          state <= ST_COUNT;
      end
      ST_COUNT: begin
        if (expire) begin
          state <= ST_LOCKED;
          countdown <= 5'h0_0;
        end else if (unit_tick) begin
          countdown <= countdown - 5'd1;
          unit_timer <= 32'h0000_0000;
        end else begin
          unit_timer <= unit_timer + 32'd1;
        end
      end
      ST_LOCKED: begin
        state <= ST_LOCKED;
      end
      default: begin
        state <= ST_IDLE;
      end
    endcase
  end
end

// recovery outputs, sampled at the expiry edge
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    recovery_load <= 1'b0;
    recovery_from_nm <= 1'b0;
    recovery_n <= 8'h00;
    recovery_m <= 7'h00;
    recovery_rate_sel <= 5'h0_0;
    recovery_ratio_sel <= 5'h0_0;
    freq_change_locked <= 1'b0;
  end else begin
    recovery_load <= expire;
    freq_change_locked <= (state == ST_LOCKED) || expire;
    if (expire) begin
      recovery_from_nm <= fallback_source_sel;
      // n and m used on timeout
      recovery_n <= fallback_divider_n;
      recovery_m <= fallback_divider_m;
      recovery_rate_sel <= latched_rate_pins;
      recovery_ratio_sel <= rate_pin_override ? sw_rate_sel :
        latched_rate_pins;
    end
  end
end

// reset pulse; a fixed width so the board sees a clean level
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    reset_timer <= 5'h0_0;
    sys_reset <= 1'b0;
  end else if ((expire && reset_on_expiry_en) ||
    (freq_change && reset_on_rate_change_en && state != ST_LOCKED)) begin
    reset_timer <= RESET_LAST[4:0];
    sys_reset <= 1'b1;
  end else if (reset_timer != 5'h0_0) begin
    reset_timer <= reset_timer - 5'd1;
  end else begin
    sys_reset <= 1'b0;
  end
end

// read port, one cycle latency
always @(posedge clk_sys or negedge resetn) begin
  if (!resetn) begin
    byte_rdata <= 8'h00;
  end else if (byte_read) begin
    // reserved bits and unmapped bytes read zero
    byte_rdata <=
      (hit(byte_index, `REG_LATCHED_PINS) & {latched_rate_pins, 3'h0}) |
      (hit(byte_index, `REG_TIMEOUT_CFG) & timeout_cfg) |
      (hit(byte_index, `REG_RESET_DRIVE) & {usb_clk_strength,
        pci_clk_strength, mid_clk_strength, reset_on_expiry_en,
        reset_on_rate_change_en, timeout_flag, watchdog_run, 1'b0}) |
      (hit(byte_index, `REG_SKEW_FIXED) & {cpu_clk_delay_trim,
        locked_bus_rate_mode, pci_clk_delay_trim, mid_clk_delay_trim}) |
      (hit(byte_index, `REG_RECOVERY_N) & fallback_divider_n);
  end
end

endmodule // clock_watchdog_recovery_ctrl
`default_nettype wire

// >>> core/README_none.v
// intentionally holds no logic
`default_nettype none
`default_nettype wire

// >>> tb/clock_watchdog_props.sv
// assertion checker for the watchdog recovery control ports
`default_nettype none
module clock_watchdog_props (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // register port
  input wire [3:0] byte_index,
  input wire byte_write,
  input wire [7:0] byte_wdata,
  input wire byte_read,
  input wire [7:0] byte_rdata,
  // events and results
  input wire freq_change,
  input wire recovery_load,
  input wire freq_change_locked,
  input wire sys_reset,
  input wire usb_clk_strength,
  input wire locked_bus_rate_mode,
  input wire timeout_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic w9;
  logic run_clr;
  logic exp_en;
  logic chg_en;
  logic [4:0] rlen;
  assign w9 = byte_write && byte_index == 4'h9;
  assign run_clr = w9 && !byte_wdata[1];
  // shadow of the two reset enables, seen only through writes
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      exp_en <= 1'b0;
      chg_en <= 1'b0;
      rlen <= 5'h0;
    end else begin
      if (w9) begin
        exp_en <= byte_wdata[4];
        chg_en <= byte_wdata[3];
      end
      rlen <= sys_reset ? rlen + 5'h1 : 5'h0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_run_clear;
    w9 && !byte_wdata[1];
  endsequence
  sequence s_flag_clear;
    w9 && byte_wdata[2];
  endsequence
  a_load_single_pulse: assert property (
    recovery_load |=> !recovery_load) else $error("load pulse too long");
  a_load_sets_flag: assert property (
    recovery_load |-> timeout_flag_out && freq_change_locked)
    else $error("expiry without flag or lock");
  a_expiry_reset_on: assert property (
    recovery_load && exp_en |-> sys_reset) else $error("no expiry reset");
  a_reset_has_cause: assert property (
    $rose(sys_reset) |-> (recovery_load && exp_en) ||
      $past(freq_change && chg_en && !freq_change_locked))
    else $error("reset pulse without cause");
  a_rate_reset_on: assert property (
    freq_change && chg_en && !freq_change_locked |=> sys_reset)
    else $error("no rate change reset");
  a_reset_pulse_width: assert property (
    $fell(sys_reset) |-> rlen == 5'd16) else $error("reset width wrong");
  a_flag_write_clear: assert property (
    s_flag_clear |=> !timeout_flag_out || recovery_load)
    else $error("flag not cleared");
  a_lock_release: assert property (
    s_run_clear |-> ##[1:3] !freq_change_locked) else $error("lock stuck");
  a_lock_holds: assert property (
    !w9 [*3] ##1 (freq_change_locked && !w9) |=> freq_change_locked)
    else $error("lock dropped");
  a_fixed_mode_locked: assert property (
    freq_change_locked && !$past(run_clr, 2) && byte_write &&
      byte_index == 4'hA |=> $stable(locked_bus_rate_mode))
    else $error("locked write taken");
  a_drive_write: assert property (
    w9 |=> usb_clk_strength == $past(byte_wdata[7]))
    else $error("drive bit not stored");
  a_unmapped_zero: assert property (
    byte_read && byte_index == 4'h3 |=> byte_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // clock_watchdog_props
bind clock_watchdog_recovery_ctrl clock_watchdog_props clock_watchdog_props_i (
  .clk_sys, .resetn, .byte_index, .byte_write, .byte_wdata, .byte_read,
  .byte_rdata, .freq_change, .recovery_load, .freq_change_locked, .sys_reset,
  .usb_clk_strength, .locked_bus_rate_mode, .timeout_flag_out);
`default_nettype wire

// >>> tb/synth_side_model.sv
// synthesizer, strap pins and software recovery settings
`default_nettype none
module synth_side_model #(
  parameter logic [4:0] STRAP = 5'h13
) (
  // clock
  input wire logic clk_sys,
  // rate change event and straps
  output logic freq_change,
  output logic [4:0] rate_select_pins,
  // recovery settings held by software
  output logic rate_pin_override,
  output logic [4:0] sw_rate_sel,
  output logic fallback_source_sel,
  output logic [6:0] fallback_divider_m
);
  timeunit 1ns;
  timeprecision 1ns;
  // straps settle long before reset release so the latch sees them
  initial begin
    freq_change = 1'b0;
    rate_select_pins = STRAP;
    rate_pin_override = 1'b0;
    sw_rate_sel = 5'h00;
    fallback_source_sel = 1'b0;
    fallback_divider_m = 7'h00;
  end
  task pulse();
    @(posedge clk_sys);
    freq_change <= 1'b1;
    @(posedge clk_sys);
    freq_change <= 1'b0;
  endtask
  task set_rec(input logic o, input logic [4:0] s, input logic f,
               input logic [6:0] m);
    @(posedge clk_sys);
    rate_pin_override <= o;
    sw_rate_sel <= s;
    fallback_source_sel <= f;
    fallback_divider_m <= m;
  endtask
endmodule // synth_side_model
`default_nettype wire

// >>> tb/clock_watchdog_recovery_ctrl_tb_top.sv
// self-checking bench for the watchdog recovery control block
`default_nettype none
module clock_watchdog_recovery_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] STRAP = 5'h13;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] byte_index = 4'h0;
  logic byte_write = 1'b0;
  logic [7:0] byte_wdata = 8'h00;
  logic byte_read = 1'b0;
  logic [7:0] byte_rdata, recovery_n, skw [3] = '{8'hB7, 8'h4A, 8'h00};
  logic [6:0] recovery_m, fallback_divider_m;
  logic [4:0] rate_select_pins, sw_rate_sel, recovery_rate_sel;
  logic [4:0] recovery_ratio_sel, latched_rate_pins;
  logic [2:0] cpu_clk_delay_trim;
  logic [1:0] pci_clk_delay_trim, mid_clk_delay_trim;
  logic freq_change, rate_pin_override, fallback_source_sel, recovery_load;
  logic recovery_from_nm, freq_change_locked, sys_reset, usb_clk_strength;
  logic pci_clk_strength, mid_clk_strength, locked_bus_rate_mode;
  logic timeout_flag_out;
  int mismatches = 0;
  int tests_run = 0;
  int n;
  always #20 clk_sys = ~clk_sys;
  // short units keep the run small; expectations scale from them
  clock_watchdog_recovery_ctrl #(.SHORT_UNIT_CYCLES(10),
    .LONG_UNIT_CYCLES(40)) clock_watchdog_recovery_ctrl_i (.clk_sys,
    .resetn, .byte_index, .byte_write, .byte_wdata, .byte_read, .byte_rdata,
    .freq_change, .rate_select_pins, .rate_pin_override, .sw_rate_sel,
    .fallback_source_sel, .fallback_divider_m, .recovery_load,
    .recovery_from_nm, .recovery_n, .recovery_m, .recovery_rate_sel,
    .recovery_ratio_sel, .freq_change_locked, .sys_reset, .usb_clk_strength,
    .pci_clk_strength, .mid_clk_strength, .cpu_clk_delay_trim,
    .locked_bus_rate_mode, .pci_clk_delay_trim, .mid_clk_delay_trim,
    .latched_rate_pins, .timeout_flag_out);
  synth_side_model #(.STRAP(STRAP)) synth_side_model_i (.clk_sys,
    .freq_change, .rate_select_pins, .rate_pin_override, .sw_rate_sel,
    .fallback_source_sel, .fallback_divider_m);
  task stop_test();
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    byte_index <= a;
    byte_wdata <= d;
    byte_write <= 1'b1;
    @(posedge clk_sys);
    byte_write <= 1'b0;
    @(negedge clk_sys);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e,
          input logic [7:0] m = 8'hFF);
    @(posedge clk_sys);
    byte_index <= a;
    byte_read <= 1'b1;
    @(posedge clk_sys);
    byte_read <= 1'b0;
    @(negedge clk_sys);
    chk(byte_rdata & m, e);
  endtask
  task start_wd();
    repeat (2) @(posedge clk_sys);
    synth_side_model_i.pulse();
  endtask
  task wait_flag();
    n = 0;
    while (timeout_flag_out !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(4'h8, 8'h3E);
    rd(4'h9, 8'h00);
    rd(4'hA, 8'h00);
    rd(4'hB, 8'h00);
    wr(4'h5, 8'h00);
    rd(4'h5, {STRAP, 3'b000}, 8'hF8);
    chk(latched_rate_pins, STRAP);
    rd(4'h3, 8'h00);
    wr(4'h8, 8'hFE);
    rd(4'h8, 8'h3E);
    wr(4'h9, 8'hE1);
    rd(4'h9, 8'hE0);
    chk({usb_clk_strength, pci_clk_strength, mid_clk_strength},
      3'h7);
    foreach (skw[i]) begin
      wr(4'hA, skw[i]);
      rd(4'hA, skw[i]);
      chk({cpu_clk_delay_trim, locked_bus_rate_mode, pci_clk_delay_trim,
        mid_clk_delay_trim}, skw[i]);
    end
    wr(4'hB, 8'hA5);
    rd(4'hB, 8'hA5);
    wr(4'h9, 8'h08);
    synth_side_model_i.pulse();
    @(negedge clk_sys);
    n = 0;
    while (sys_reset === 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, 16);
    wr(4'h9, 8'h00);
    synth_side_model_i.pulse();
    @(negedge clk_sys);
    chk(sys_reset, 0);
    // full short count, reset on expiry, recovery from n and m
    synth_side_model_i.set_rec(1'b1, 5'h0C, 1'b1, 7'h55);
    wr(4'h9, 8'h12);
    start_wd();
    wait_flag();
    chk(n >= 310 && n <= 313, 1);
    chk({recovery_load, sys_reset, freq_change_locked}, 3'h7);
    chk({recovery_from_nm, recovery_n, recovery_m}, 16'hD2D5);
    chk(recovery_ratio_sel, 5'h0C);
    rd(4'h9, 8'h16);
    wr(4'hA, 8'h10);
    chk(locked_bus_rate_mode, 0);
    wr(4'h9, 8'h16);
    chk({timeout_flag_out, freq_change_locked}, 2'b01);
    wr(4'h9, 8'h00);
    // lock drops two edges after the run bit clears
    repeat (2) @(negedge clk_sys);
    chk(freq_change_locked, 0);
    wr(4'hA, 8'h10);
    chk(locked_bus_rate_mode, 1);
    // long unit, stopped mid-count, then a clean run from reload
    synth_side_model_i.set_rec(1'b0, 5'h0C, 1'b0, 7'h55);
    wr(4'h8, 8'h03);
    wr(4'h9, 8'h02);
    start_wd();
    repeat (20) @(posedge clk_sys);
    wr(4'h9, 8'h00);
    repeat (60) @(negedge clk_sys);
    chk(timeout_flag_out, 0);
    wr(4'h9, 8'h02);
    start_wd();
    wait_flag();
    chk(n >= 40 && n <= 43, 1);
    chk({sys_reset, recovery_from_nm}, 2'b00);
    chk({recovery_ratio_sel, recovery_rate_sel}, {STRAP, STRAP});
    stop_test();
  end
  initial begin
    #(40 * 5000);
    mismatches++;
    stop_test();
  end
endmodule // clock_watchdog_recovery_ctrl_tb_top
`default_nettype wire
